// ---- rtl/fxu_pkg.sv ----
// Package for the flags transfer unit: register offsets, flag bit positions,
// pop masks, operation codes and reset values.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package fxu_pkg;

  // Register byte offsets
  localparam logic [7:0] FXU_OFF_FLAGS    = 8'h00;
  localparam logic [7:0] FXU_OFF_ACC_HIGH = 8'h04;
  localparam logic [7:0] FXU_OFF_POP_LO   = 8'h08;
  localparam logic [7:0] FXU_OFF_POP_HI   = 8'h0C;
  localparam logic [7:0] FXU_OFF_PUSH_LO  = 8'h10;
  localparam logic [7:0] FXU_OFF_PUSH_HI  = 8'h14;
  localparam logic [7:0] FXU_OFF_CONTEXT  = 8'h18;
  localparam logic [7:0] FXU_OFF_COMMAND  = 8'h1C;
  localparam logic [7:0] FXU_OFF_STATUS   = 8'h20;

  // Flag bit positions
  localparam int FXU_BIT_CARRY   = 0;
  localparam int FXU_BIT_FIXED1  = 1;
  localparam int FXU_BIT_PARITY  = 2;
  localparam int FXU_BIT_AUX     = 4;
  localparam int FXU_BIT_ZERO    = 6;
  localparam int FXU_BIT_SIGN    = 7;
  localparam int FXU_BIT_INT_EN  = 9;
  localparam int FXU_BIT_IO_PRIVILEGE_LEVEL_LO = 12;
  localparam int FXU_BIT_IO_PRIVILEGE_LEVEL_HI = 13;
  localparam int FXU_BIT_RESUME  = 16;
  localparam int FXU_BIT_V86     = 17;
  localparam int FXU_BIT_ALIGN   = 18;
  localparam int FXU_BIT_QUERY   = 21;

  // Accumulator-high byte positions of the five status flags
  localparam int FXU_AH_SIGN   = 7;
  localparam int FXU_AH_ZERO   = 6;
  localparam int FXU_AH_AUX    = 4;
  localparam int FXU_AH_PARITY = 2;
  localparam int FXU_AH_CARRY  = 0;

  // Pop masks: bits 11,10,8,7,6,4,2,0 always; 18 and 21 on the wide pop
  localparam logic [31:0] FXU_POP_WORD_MASK = 32'h0000_0DD5;
  localparam logic [31:0] FXU_POP_WIDE_MASK = 32'h0024_0000;
  localparam logic [31:0] FXU_IO_PRIVILEGE_LEVEL_MASK     = 32'h0000_3000;
  localparam logic [31:0] FXU_INT_EN_MASK   = 32'h0000_0200;
  localparam logic [31:0] FXU_WORD_MASK     = 32'h0000_FFFF;
  localparam logic [31:0] FXU_PUSH_CLR_MASK = 32'h0003_0000;

  // Reset values
  localparam logic [31:0] FXU_FLAGS_RESET = 32'h0000_0002;
  localparam logic [7:0]  FXU_ACC_RESET   = 8'h00;
  localparam logic [7:0]  FXU_AH_UNDEF    = 8'h00;
  localparam logic [1:0]  FXU_CPL_TOP     = 2'h0;

  // Context register fields
  localparam int FXU_CTX_CPL_LO = 0;
  localparam int FXU_CTX_CPL_HI = 1;
  localparam int FXU_CTX_LONG   = 2;
  localparam int FXU_CTX_FEAT   = 3;

  // Status register fields
  localparam int FXU_ST_REFUSED = 0;
  localparam int FXU_ST_WIDE    = 1;
  localparam int FXU_ST_INT_EN  = 2;

  // Operation codes written to the command register
  localparam logic [3:0] FXU_OP_NONE      = 4'h0;
  localparam logic [3:0] FXU_OP_LOAD_AH   = 4'h1;
  localparam logic [3:0] FXU_OP_STORE_AH  = 4'h2;
  localparam logic [3:0] FXU_OP_PUSH_WORD = 4'h3;
  localparam logic [3:0] FXU_OP_PUSH_WIDE = 4'h4;
  localparam logic [3:0] FXU_OP_POP_WORD  = 4'h5;
  localparam logic [3:0] FXU_OP_POP_WIDE  = 4'h6;
  localparam logic [3:0] FXU_OP_SET_IE    = 4'h7;
  localparam logic [3:0] FXU_OP_CLR_IE    = 4'h8;

endpackage

// ---- rtl/fxu_pop_merge.sv ----
// Merge of a popped flag image into the flags register.
// Assumes the caller supplies the current privilege level and the old flags.
`timescale 1ns/1ps
`default_nettype none

module fxu_pop_merge
  import fxu_pkg::*;
(
  // Inputs
  input  wire logic [31:0] old_flags,
  input  wire logic [31:0] popped,
  input  wire logic        wide,
  input  wire logic [1:0]  current_privilege_level,
  // Result
  output logic      [31:0] new_flags
);

  logic [31:0] mask;
  logic [1:0]  io_privilege_level;

  always_comb begin
    io_privilege_level = old_flags[FXU_BIT_IO_PRIVILEGE_LEVEL_HI:FXU_BIT_IO_PRIVILEGE_LEVEL_LO];
    mask = FXU_POP_WORD_MASK;
    if (wide) begin
      mask = mask | FXU_POP_WIDE_MASK;
    end
    if (current_privilege_level == FXU_CPL_TOP) begin
      mask = mask | FXU_IO_PRIVILEGE_LEVEL_MASK;
    end
    if (io_privilege_level >= current_privilege_level) begin
      mask = mask | FXU_INT_EN_MASK;
    end
    new_flags = (old_flags & ~mask) | (popped & mask);
    new_flags[FXU_BIT_FIXED1] = 1'b1;
  end

endmodule

`default_nettype wire

// ---- rtl/fxu_top.sv ----
// Flags transfer unit: flags register, accumulator-high transfers, flag
// push and pop images, interrupt enable control and maskable input gating.
// Assumes a classic Wishbone master and a stack port that takes push images.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Load to accumulator high puts sign, zero, aux, parity, carry at 7,6,4,2,0.
// - That load leaves bits 5,3,1 undefined and flags unchanged.
// - Store from accumulator high writes bits 7,6,4,2,0 into the five flags.
// - Word push writes only the low 16 flag bits.
// - Wide push writes all flags with resume and virtual-8086 bits zero.
// - Word pop always updates bits 11,10,8,7,6,4,2,0.
// - At privilege level 0 a pop also updates the I/O privilege field.
// - If I/O privilege >= current privilege a pop also updates interrupt enable.
// - Wide pop may also update alignment check and query toggle bits.
// - Wide pop uses the same privilege gating as the word pop.
// - Maskable interrupt requests are serviced only while interrupt enable is set.
// - Set and clear interrupt enable operations, gated by privilege only (I/O privilege >= current privilege).
// - In 64-bit mode accumulator-high transfers need the feature bit set.
// - In 64-bit mode the wide push writes a 64-bit image, resume and v86 zero.
// - In 64-bit mode wide pop loads low 32 bits and zeroes upper bits.
// - In 64-bit mode word push and pop behave as outside it.
module fxu_top
  import fxu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Stack memory port
  output logic             stack_push_stb,
  output logic      [63:0] stack_push_data,
  output logic             stack_push_wide,
  // Interrupt gating
  input  wire logic        maskable_interrupt_input,
  output logic             int_service
);

  typedef struct packed {
    logic [31:0] flags;
    logic [7:0]  acc_high;
    logic [63:0] pop_val;
    logic [63:0] push_img;
    logic [1:0]  current_privilege_level;
    logic        long_mode;
    logic        feat;
    logic        refused;
    logic        push_wide;
    logic        push_stb;
    logic        ack;
    logic [31:0] rdata;
    logic        int_take;
  } fxu_state_type;

  fxu_state_type s_q;
  fxu_state_type s_d;

  logic [31:0] pop_flags;
  logic        pop_is_wide;
  logic        wr_take;
  logic        rd_take;

  // Elaboration checks: masks and field positions must agree with each other
  if ((FXU_POP_WORD_MASK & FXU_POP_WIDE_MASK) != 32'h0000_0000) begin : g_chk_pop_overlap
    $error("word and wide pop masks overlap");
  end

  if ((FXU_POP_WORD_MASK & FXU_IO_PRIVILEGE_LEVEL_MASK) != 32'h0000_0000) begin : g_chk_word_io_privilege_level
    $error("privilege field inside the ungated pop mask");
  end

  if ((FXU_POP_WORD_MASK & FXU_INT_EN_MASK) != 32'h0000_0000) begin : g_chk_word_ie
    $error("interrupt enable inside the ungated pop mask");
  end

  if (FXU_IO_PRIVILEGE_LEVEL_MASK != ((32'h1 << FXU_BIT_IO_PRIVILEGE_LEVEL_HI) | (32'h1 << FXU_BIT_IO_PRIVILEGE_LEVEL_LO))) begin : g_chk_io_privilege_level
    $error("privilege field mask disagrees with its bit positions");
  end

  if (FXU_BIT_IO_PRIVILEGE_LEVEL_HI != FXU_BIT_IO_PRIVILEGE_LEVEL_LO + 1) begin : g_chk_io_privilege_level_pair
    $error("privilege field bits are not adjacent");
  end

  if (FXU_INT_EN_MASK != (32'h1 << FXU_BIT_INT_EN)) begin : g_chk_ie_mask
    $error("interrupt enable mask disagrees with its bit position");
  end

  if (FXU_POP_WIDE_MASK != ((32'h1 << FXU_BIT_ALIGN) | (32'h1 << FXU_BIT_QUERY))) begin : g_chk_wide
    $error("wide pop mask disagrees with its bit positions");
  end

  if (FXU_PUSH_CLR_MASK != ((32'h1 << FXU_BIT_RESUME) | (32'h1 << FXU_BIT_V86))) begin : g_chk_clr
    $error("push clear mask disagrees with its bit positions");
  end

  if ((FXU_PUSH_CLR_MASK & FXU_WORD_MASK) != 32'h0000_0000) begin : g_chk_push_word
    $error("cleared push bits fall inside the word image");
  end

  if (FXU_FLAGS_RESET[FXU_BIT_FIXED1] != 1'b1) begin : g_chk_fixed1
    $error("reset value must hold the fixed one bit");
  end

  if (FXU_AH_SIGN >= $bits(FXU_ACC_RESET)) begin : g_chk_ah_pos
    $error("accumulator-high flag position outside the byte");
  end

  // Context fields are written through byte lane 0 only
  if (FXU_CTX_FEAT >= $bits(FXU_AH_UNDEF)) begin : g_chk_ctx_lane
    $error("context field outside byte lane 0");
  end

  if (FXU_BIT_QUERY >= $bits(FXU_FLAGS_RESET)) begin : g_chk_query_pos
    $error("query toggle bit outside the flags register");
  end

  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign pop_is_wide = (wb_dat_i[3:0] == FXU_OP_POP_WIDE);

  fxu_pop_merge u_merge (
    .old_flags (s_q.flags),
    .popped    (s_q.pop_val[31:0]),
    .wide      (pop_is_wide),
    .current_privilege_level       (s_q.current_privilege_level),
    .new_flags (pop_flags)
  );

  // A write takes effect at the edge where the master sees ack
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;
  assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;

  always_comb begin
    logic [31:0] tmp;
    logic [31:0] img;
    logic [1:0]  io_privilege_level;
    logic        ah_ok;
    tmp  = 32'h0000_0000;
    img  = 32'h0000_0000;
    s_d  = s_q;
    io_privilege_level = s_q.flags[FXU_BIT_IO_PRIVILEGE_LEVEL_HI:FXU_BIT_IO_PRIVILEGE_LEVEL_LO];
    ah_ok = !s_q.long_mode || s_q.feat;
    s_d.push_stb = 1'b0;
    s_d.ack      = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.int_take = maskable_interrupt_input && s_q.flags[FXU_BIT_INT_EN];

    // Read data registered with the ack
    if (rd_take) begin
      unique case (wb_adr_i)
        FXU_OFF_FLAGS:    s_d.rdata = s_q.flags;
        FXU_OFF_ACC_HIGH: s_d.rdata = {24'h00_0000, s_q.acc_high};
        FXU_OFF_POP_LO:   s_d.rdata = s_q.pop_val[31:0];
        FXU_OFF_POP_HI:   s_d.rdata = s_q.pop_val[63:32];
        FXU_OFF_PUSH_LO:  s_d.rdata = s_q.push_img[31:0];
        FXU_OFF_PUSH_HI:  s_d.rdata = s_q.push_img[63:32];
        FXU_OFF_CONTEXT: begin
          tmp[FXU_CTX_CPL_HI:FXU_CTX_CPL_LO] = s_q.current_privilege_level;
          tmp[FXU_CTX_LONG] = s_q.long_mode;
          tmp[FXU_CTX_FEAT] = s_q.feat;
          s_d.rdata = tmp;
        end
        FXU_OFF_STATUS: begin
          tmp[FXU_ST_REFUSED] = s_q.refused;
          tmp[FXU_ST_WIDE]    = s_q.push_wide;
          tmp[FXU_ST_INT_EN]  = s_q.flags[FXU_BIT_INT_EN];
          s_d.rdata = tmp;
        end
        default:          s_d.rdata = 32'h0000_0000;
      endcase
    end

    if (wr_take) begin
      unique case (wb_adr_i)
        FXU_OFF_FLAGS: begin
          s_d.flags = lane_merge(s_q.flags, wb_dat_i, wb_sel_i);
          s_d.flags[FXU_BIT_FIXED1] = 1'b1;
        end
        FXU_OFF_ACC_HIGH: begin
          if (wb_sel_i[0]) begin
            s_d.acc_high = wb_dat_i[7:0];
          end
        end
        FXU_OFF_POP_LO: begin
          s_d.pop_val[31:0] = lane_merge(s_q.pop_val[31:0], wb_dat_i, wb_sel_i);
        end
        FXU_OFF_POP_HI: begin
          s_d.pop_val[63:32] = lane_merge(s_q.pop_val[63:32], wb_dat_i, wb_sel_i);
        end
        FXU_OFF_CONTEXT: begin
          if (wb_sel_i[0]) begin
            s_d.current_privilege_level       = wb_dat_i[FXU_CTX_CPL_HI:FXU_CTX_CPL_LO];
            s_d.long_mode = wb_dat_i[FXU_CTX_LONG];
            s_d.feat      = wb_dat_i[FXU_CTX_FEAT];
          end
        end
        FXU_OFF_COMMAND: begin
          if (wb_sel_i[0]) begin
            s_d.refused = 1'b0;
            unique case (wb_dat_i[3:0])
              FXU_OP_LOAD_AH: begin
                if (ah_ok) begin
                  s_d.acc_high = FXU_AH_UNDEF;
                  s_d.acc_high[FXU_AH_SIGN]   = s_q.flags[FXU_BIT_SIGN];
                  s_d.acc_high[FXU_AH_ZERO]   = s_q.flags[FXU_BIT_ZERO];
                  s_d.acc_high[FXU_AH_AUX]    = s_q.flags[FXU_BIT_AUX];
                  s_d.acc_high[FXU_AH_PARITY] = s_q.flags[FXU_BIT_PARITY];
                  s_d.acc_high[FXU_AH_CARRY]  = s_q.flags[FXU_BIT_CARRY];
                end else begin
                  s_d.refused = 1'b1;
                end
              end
              FXU_OP_STORE_AH: begin
                if (ah_ok) begin
                  s_d.flags[FXU_BIT_SIGN]   = s_q.acc_high[FXU_AH_SIGN];
                  s_d.flags[FXU_BIT_ZERO]   = s_q.acc_high[FXU_AH_ZERO];
                  s_d.flags[FXU_BIT_AUX]    = s_q.acc_high[FXU_AH_AUX];
                  s_d.flags[FXU_BIT_PARITY] = s_q.acc_high[FXU_AH_PARITY];
                  s_d.flags[FXU_BIT_CARRY]  = s_q.acc_high[FXU_AH_CARRY];
                end else begin
                  s_d.refused = 1'b1;
                end
              end
              FXU_OP_PUSH_WORD: begin
                s_d.push_img  = {32'h0000_0000, s_q.flags & FXU_WORD_MASK};
                s_d.push_wide = 1'b0;
                s_d.push_stb  = 1'b1;
              end
              FXU_OP_PUSH_WIDE: begin
                img = s_q.flags & ~FXU_PUSH_CLR_MASK;
                s_d.push_img  = {32'h0000_0000, img};
                s_d.push_wide = s_q.long_mode;
                s_d.push_stb  = 1'b1;
              end
              FXU_OP_POP_WORD: begin
                s_d.flags = pop_flags;
              end
              FXU_OP_POP_WIDE: begin
                // Flags hold 32 bits, so the upper half always reads zero
                s_d.flags = pop_flags;
              end
              FXU_OP_SET_IE: begin
                if (io_privilege_level >= s_q.current_privilege_level) begin
                  s_d.flags[FXU_BIT_INT_EN] = 1'b1;
                end else begin
                  s_d.refused = 1'b1;
                end
              end
              FXU_OP_CLR_IE: begin
                if (io_privilege_level >= s_q.current_privilege_level) begin
                  s_d.flags[FXU_BIT_INT_EN] = 1'b0;
                end else begin
                  s_d.refused = 1'b1;
                end
              end
              default: begin
                s_d.refused = 1'b1;
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q           <= '0;
      s_q.flags     <= FXU_FLAGS_RESET;
      s_q.acc_high  <= FXU_ACC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o        = s_q.rdata;
  assign wb_ack_o        = s_q.ack;
  assign stack_push_stb  = s_q.push_stb;
  assign stack_push_data = s_q.push_img;
  assign stack_push_wide = s_q.push_wide;
  assign int_service     = s_q.int_take;

endmodule

`default_nettype wire

// ---- bench/fxu_checker.sv ----
// Port checker for fxu_top: bus answer timing, push strobes, interrupt gating.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fxu_checker
  import fxu_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Stack port and interrupt
  input wire logic        stack_push_stb,
  input wire logic [63:0] stack_push_data,
  input wire logic        maskable_interrupt_input,
  input wire logic        int_service
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cmd_wr;
    wb_ack_o && wb_we_i && wb_adr_i == FXU_OFF_COMMAND;
  endsequence
  sequence s_push_cmd;
    s_cmd_wr ##0 (wb_dat_i[3:0] == FXU_OP_PUSH_WORD || wb_dat_i[3:0] == FXU_OP_PUSH_WIDE);
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_PUSH_AFTER_CMD: assert property (s_push_cmd |=> stack_push_stb ##1 !stack_push_stb)
    else $error("push strobe not one cycle after push command");
  AST_PUSH_CAUSE: assert property (stack_push_stb |-> $past(wb_ack_o && wb_we_i
    && wb_adr_i == FXU_OFF_COMMAND)) else $error("push strobe without command");
  AST_WORD_IMAGE: assert property (s_cmd_wr ##0 wb_dat_i[3:0] == FXU_OP_PUSH_WORD
    |=> stack_push_data[63:16] == 48'h0) else $error("word push image too wide");
  AST_NO_RV_IMAGE: assert property (stack_push_stb |-> stack_push_data[17:16] == 2'h0)
    else $error("resume or v86 bit in pushed image");
  AST_UPPER_ZERO: assert property (stack_push_stb |-> stack_push_data[63:32] == 32'h0)
    else $error("upper flag bits not zero in image");
  AST_INT_GATE: assert property (int_service |-> $past(maskable_interrupt_input))
    else $error("service without interrupt request");
  AST_INT_DROP: assert property (!maskable_interrupt_input |=> !int_service)
    else $error("service held after request fell");
endmodule
bind fxu_top fxu_checker chk_i (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_ack_o, .stack_push_stb, .stack_push_data, .maskable_interrupt_input,
  .int_service);
`default_nettype wire

// ---- bench/fxu_stack_model.sv ----
// Stack memory port model: keeps the latest pushed image and a push count.
// Assumes one-beat push strobes from fxu_top on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module fxu_stack_model (
  // Push side
  input  wire logic        clk,
  input  wire logic        stack_push_stb,
  input  wire logic [63:0] stack_push_data,
  input  wire logic        stack_push_wide,
  // Observation
  output logic      [63:0] top_image,
  output logic             top_wide,
  output logic      [7:0]  depth
);
  initial begin
    top_image = 64'h0;
    top_wide = 1'b0;
    depth = 8'h00;
  end
  always @(posedge clk) begin
    if (stack_push_stb === 1'b1) begin
      top_image <= stack_push_data;
      top_wide <= stack_push_wide;
      depth <= depth + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for fxu_top over classic Wishbone.
// Assumes the stack model beside the design and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fxu_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic        maskable_interrupt_input = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, stack_push_stb, stack_push_wide, int_service, img_wide;
  logic [63:0] stack_push_data, img;
  logic [7:0]  depth;
  int          err_total = 0, checks_done = 0, cycles = 0;
  int          pos [5] = '{0, 2, 4, 6, 7};
  logic [3:0]  t_ctx [8] = '{4'h0, 4'h0, 4'h3, 4'h3, 4'h1, 4'h2, 4'h4, 4'h4};
  logic [3:0]  t_op [8] = '{4'h5, 4'h6, 4'h5, 4'h6, 4'h5, 4'h6, 4'h5, 4'h6};
  logic [31:0] t_old [8] = '{32'h2, 32'h2, 32'h2, 32'h3002, 32'h243FD7, 32'h1002, 32'h2, 32'h2};
  logic [31:0] t_lo [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0,
                            32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF};
  logic [31:0] t_exp [8] = '{32'h3FD7, 32'h243FD7, 32'hDD7, 32'h243FD7, 32'h243002,
                             32'h1002, 32'h3FD7, 32'h243FD7};
  fxu_top uut (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .stack_push_stb, .stack_push_data, .stack_push_wide,
    .maskable_interrupt_input, .int_service);
  fxu_stack_model stack_i (.clk, .stack_push_stb, .stack_push_data, .stack_push_wide,
    .top_image(img), .top_wide(img_wide), .depth);
  always #5 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic cmd(input logic [3:0] op);
    wr(FXU_OFF_COMMAND, {28'h0, op});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(FXU_OFF_FLAGS, FXU_FLAGS_RESET);
    rdc(FXU_OFF_CONTEXT, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    rdc(8'h3C, 32'h0);
    foreach (pos[i]) begin
      wr(FXU_OFF_FLAGS, 32'h2 | (32'h1 << pos[i]));
      cmd(FXU_OP_LOAD_AH);
      rdc(FXU_OFF_ACC_HIGH, 32'h1 << pos[i]);
      wr(FXU_OFF_ACC_HIGH, ~(32'h1 << pos[i]) & 32'hFF);
      cmd(FXU_OP_STORE_AH);
      rdc(FXU_OFF_FLAGS, 32'h2 | (32'hD5 & ~(32'h1 << pos[i])));
    end
    wr(FXU_OFF_FLAGS, 32'hCFF);
    cmd(FXU_OP_LOAD_AH);
    rdc(FXU_OFF_ACC_HIGH, 32'hD5);
    rdc(FXU_OFF_FLAGS, 32'hCFF);
    wr(FXU_OFF_ACC_HIGH, 32'h0);
    cmd(FXU_OP_STORE_AH);
    rdc(FXU_OFF_FLAGS, 32'hC2A);
    wr(FXU_OFF_FLAGS, 32'h273FD7);
    cmd(FXU_OP_PUSH_WORD);
    rdc(FXU_OFF_PUSH_LO, 32'h3FD7);
    chk(img[31:0], 32'h3FD7);
    cmd(FXU_OP_PUSH_WIDE);
    rdc(FXU_OFF_PUSH_LO, 32'h243FD7);
    chk({img_wide, img[62:32]}, 32'h0);
    wr(FXU_OFF_CONTEXT, 32'h4);
    cmd(FXU_OP_PUSH_WIDE);
    rdc(FXU_OFF_PUSH_HI, 32'h0);
    chk({img_wide, img[62:32]}, 32'h80000000);
    cmd(FXU_OP_PUSH_WORD);
    rdc(FXU_OFF_PUSH_LO, 32'h3FD7);
    chk({img_wide, img[30:0]}, 32'h3FD7);
    wr(FXU_OFF_ACC_HIGH, 32'h0);
    cmd(FXU_OP_LOAD_AH);
    rdc(FXU_OFF_ACC_HIGH, 32'h0);
    wr(FXU_OFF_CONTEXT, 32'hC);
    cmd(FXU_OP_LOAD_AH);
    rdc(FXU_OFF_ACC_HIGH, 32'hD5);
    wr(FXU_OFF_POP_HI, 32'hFFFFFFFF);
    foreach (t_ctx[i]) begin
      wr(FXU_OFF_CONTEXT, {28'h0, t_ctx[i]});
      wr(FXU_OFF_FLAGS, t_old[i]);
      wr(FXU_OFF_POP_LO, t_lo[i]);
      cmd(t_op[i]);
      rdc(FXU_OFF_FLAGS, t_exp[i]);
    end
    cmd(FXU_OP_PUSH_WIDE);
    rdc(FXU_OFF_PUSH_HI, 32'h0);
    wr(FXU_OFF_CONTEXT, 32'h0);
    wr(FXU_OFF_FLAGS, 32'h2);
    maskable_interrupt_input <= 1'b1;
    rdc(FXU_OFF_FLAGS, 32'h2);
    chk({31'h0, int_service}, 32'h0);
    cmd(FXU_OP_SET_IE);
    rdc(FXU_OFF_FLAGS, 32'h202);
    chk({31'h0, int_service}, 32'h1);
    cmd(4'h9);
    rdc(FXU_OFF_STATUS, 32'h7);
    cmd(FXU_OP_CLR_IE);
    rdc(FXU_OFF_FLAGS, 32'h2);
    chk({31'h0, int_service}, 32'h0);
    wr(FXU_OFF_CONTEXT, 32'h3);
    cmd(FXU_OP_SET_IE);
    rdc(FXU_OFF_FLAGS, 32'h2);
    rdc(FXU_OFF_STATUS, 32'h3);
    chk({24'h0, depth}, 32'h5);
    report_and_stop();
  end
endmodule
`default_nettype wire
